// ===== verilog/cbj_core.sv
module cbj_core
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     start_i,
    input  wire logic [7:0]               opcode_i,
    input  wire logic [7:0]               op1_i,
    input  wire logic [7:0]               op2_i,
    input  wire logic [cbj_pkg::PC_W-1:0] pc_i,
    input  wire logic [cbj_pkg::PC_W-1:0] stack_pc_i,
    input  wire logic                     flag_z_i,
    input  wire logic                     flag_c_i,
    input  wire logic                     saved_z_i,
    input  wire logic                     saved_c_i,
    input  wire logic [7:0]               mem_data_i,
    input  wire logic                     wdg_sel_i,
    output logic                          busy_o,
    output logic                          done_o,
    output logic                          handled_o,
    output logic                          illegal_o,
    output logic      [1:0]               len_o,
    output logic      [cbj_pkg::PC_W-1:0] next_pc_o,
    output logic      [cbj_pkg::PC_W-1:0] ret_pc_o,
    output logic                          z_o,
    output logic                          c_o,
    output logic      [7:0]               data_addr_o,
    output logic      [7:0]               wr_data_o,
    output logic                          wr_en_o,
    output logic                          push_o,
    output logic                          pop_o,
    output logic                          wait_req_o,
    output logic                          stop_req_o
);
    import cbj_pkg::*;

    cbj_cls_t   dec_cls;
    logic [1:0] dec_len;
    logic [2:0] dec_cyc;
    logic [2:0] dec_bit;
    logic       take;
    logic       finish;
    logic       cond_met;
    logic       tbit;
    logic       btb_taken;

    cbj_decode u_decode
    (
        .opcode_i (opcode_i),
        .cls_o    (dec_cls),
        .len_o    (dec_len),
        .cyc_o    (dec_cyc),
        .bit_o    (dec_bit)
    );

    // ========================================================================
    // Sequencing.
    cbj_state_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic       busy_nxt, done_nxt;
    logic [4:0] pend_r, pend_nxt;
    logic [4:0] act_r, act_nxt;

    assign take   = (state_r == ST_IDLE) && start_i;
    assign finish = (state_r == ST_RUN) && (cnt_r == 3'h1);

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_o;
        done_nxt  = 1'b0;
        act_nxt   = 5'h00;
        case (state_r)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    state_nxt = ST_RUN;
                    cnt_nxt   = dec_cyc - 3'h1;
                    busy_nxt  = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (cnt_r == 3'h1)
                begin
                    state_nxt = ST_IDLE;
                    busy_nxt  = 1'b0;
                    done_nxt  = 1'b1;
                    act_nxt   = pend_r;
                end
                else
                begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 3'h0;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            act_r   <= 5'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_o  <= busy_nxt;
            done_o  <= done_nxt;
            act_r   <= act_nxt;
        end
    end

    assign wr_en_o    = act_r[4];
    assign push_o     = act_r[3];
    assign pop_o      = act_r[2];
    assign wait_req_o = act_r[1];
    assign stop_req_o = act_r[0];

    // ========================================================================
    // Execution results.
    logic                handled_nxt, illegal_nxt, z_nxt, c_nxt;
    logic [1:0]          len_nxt;
    logic [PC_W-1:0]     next_pc_nxt, ret_pc_nxt;
    logic [7:0]          addr_nxt, wr_data_nxt;

    assign tbit      = mem_data_i[dec_bit];
    assign btb_taken = opcode_i[4] ? tbit : !tbit;

    always_comb
    begin
        case (opcode_i[2:1])
            COND_NZ: cond_met = !flag_z_i;
            COND_NC: cond_met = !flag_c_i;
            COND_Z:  cond_met = flag_z_i;
            default: cond_met = flag_c_i;
        endcase
    end

    always_comb
    begin
        handled_nxt = handled_o;
        illegal_nxt = illegal_o;
        len_nxt     = len_o;
        next_pc_nxt = next_pc_o;
        ret_pc_nxt  = ret_pc_o;
        z_nxt       = z_o;
        c_nxt       = c_o;
        addr_nxt    = data_addr_o;
        wr_data_nxt = wr_data_o;
        pend_nxt    = pend_r;
        if (take)
        begin
            handled_nxt = (dec_cls != CLS_OTHER) && (dec_cls != CLS_ILL);
            illegal_nxt = (dec_cls == CLS_ILL);
            len_nxt     = dec_len;
            next_pc_nxt = pc_i;
            ret_pc_nxt  = pc_i + JMP_NEXT;
            z_nxt       = flag_z_i;
            c_nxt       = flag_c_i;
            addr_nxt    = op1_i;
            wr_data_nxt = mem_data_i;
            pend_nxt    = 5'h00;
            case (dec_cls)
                CLS_SBR:
                    next_pc_nxt = pc_i + SBR_BIAS +
                                  (cond_met ? sext5(opcode_i[7:3]) : 12'h000);
                CLS_BTB:
                begin
                    c_nxt       = tbit;
                    next_pc_nxt = btb_taken ? (pc_i + BTB_BIAS + sext8(op2_i))
                                            : (pc_i + BTB_NEXT);
                end
                CLS_BSC:
                begin
                    wr_data_nxt          = mem_data_i;
                    wr_data_nxt[dec_bit] = opcode_i[4];
                    pend_nxt             = 5'h10;
                end
                CLS_JP, CLS_CALL:
                begin
                    next_pc_nxt = {opcode_i[7:4], op1_i};
                    pend_nxt    = (dec_cls == CLS_CALL) ? 5'h08 : 5'h00;
                end
                CLS_NOP:
                    next_pc_nxt = pc_i + SBR_BIAS;
                CLS_RET:
                begin
                    next_pc_nxt = stack_pc_i;
                    pend_nxt    = 5'h04;
                end
                CLS_INTERRUPT_EXIT:
                begin
                    next_pc_nxt = stack_pc_i;
                    z_nxt       = saved_z_i;
                    c_nxt       = saved_c_i;
                    pend_nxt    = 5'h04;
                end
                CLS_STOP:
                begin
                    next_pc_nxt = pc_i + SBR_BIAS;
                    pend_nxt    = wdg_sel_i ? 5'h02 : 5'h01;
                end
                CLS_WAIT:
                begin
                    next_pc_nxt = pc_i + SBR_BIAS;
                    pend_nxt    = 5'h02;
                end
                default:
                    next_pc_nxt = pc_i;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            handled_o   <= 1'b0;
            illegal_o   <= 1'b0;
            len_o       <= 2'h0;
            next_pc_o   <= 12'h000;
            ret_pc_o    <= 12'h000;
            z_o         <= 1'b0;
            c_o         <= 1'b0;
            data_addr_o <= 8'h00;
            wr_data_o   <= 8'h00;
            pend_r      <= 5'h00;
        end
        else
        begin
            handled_o   <= handled_nxt;
            illegal_o   <= illegal_nxt;
            len_o       <= len_nxt;
            next_pc_o   <= next_pc_nxt;
            ret_pc_o    <= ret_pc_nxt;
            z_o         <= z_nxt;
            c_o         <= c_nxt;
            data_addr_o <= addr_nxt;
            wr_data_o   <= wr_data_nxt;
            pend_r      <= pend_nxt;
        end
    end

    // ========================================================================
    // Checks.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_BIT_TIMING: assert property ((take && dec_cls == CLS_BSC) |=>
        !done_o [*3] ##1 (done_o && wr_en_o && z_o == $past(flag_z_i, 4)))
        else $error("bit modify timing or flags wrong");
    AST_BIT_FIELD: assert property ((take && dec_cls == CLS_BSC) |=>
        wr_data_o[$past(dec_bit)] == $past(opcode_i[4]) &&
        ((wr_data_o ^ $past(mem_data_i)) & ~(8'h01 << $past(dec_bit))) == 8'h00)
        else $error("bit modify touched the wrong bit");
    AST_CTRL_TIMING: assert property ((take && dec_len == LEN_ONE &&
        dec_cls != CLS_SBR) |-> ##1 (len_o == LEN_ONE) ##1 done_o)
        else $error("control instruction timing wrong");
    AST_CTRL_FLAGS: assert property ((take && (dec_cls == CLS_NOP ||
        dec_cls == CLS_RET || dec_cls == CLS_WAIT)) |=>
        (z_o == $past(flag_z_i) && c_o == $past(flag_c_i)))
        else $error("control instruction changed flags");
    AST_HALT_SWAP: assert property ((take && dec_cls == CLS_STOP && wdg_sel_i) |->
        ##2 (wait_req_o && !stop_req_o))
        else $error("halt not replaced by idle");
    AST_JUMP_TIMING: assert property ((take && (dec_cls == CLS_JP ||
        dec_cls == CLS_CALL)) |-> ##1 busy_o [*3] ##1 (done_o && !busy_o))
        else $error("jump timing wrong");
    AST_JUMP_TARGET: assert property ((take && dec_cls == CLS_JP) |=>
        next_pc_o == {$past(opcode_i[7:4]), $past(op1_i)})
        else $error("long jump target wrong");
    AST_SHORT_FALL: assert property ((take && dec_cls == CLS_SBR && !cond_met) |=>
        next_pc_o == $past(pc_i) + SBR_BIAS)
        else $error("untaken short branch moved wrongly");
    AST_BTB_TARGET: assert property ((take && dec_cls == CLS_BTB && btb_taken) |=>
        next_pc_o == $past(pc_i) + BTB_BIAS + sext8($past(op2_i)))
        else $error("bit test branch target wrong");
    AST_BTB_CARRY: assert property ((take && dec_cls == CLS_BTB) |=>
        c_o == $past(mem_data_i[dec_bit]))
        else $error("tested bit not in carry");
    AST_ILLEGAL: assert property ((take && opcode_i[3:0] == LOW_ILL5 &&
        !opcode_i[4]) |=> (illegal_o && !handled_o))
        else $error("illegal opcode accepted");
    AST_COND_Z: assert property ((take && dec_cls == CLS_SBR &&
        opcode_i[2:1] == COND_Z) |=> next_pc_o == $past(pc_i) + SBR_BIAS +
        ($past(flag_z_i) ? sext5($past(opcode_i[7:3])) : 12'h000))
        else $error("zero condition selected wrongly");

    COV_CALL: cover property (take && dec_cls == CLS_CALL ##4 push_o);
    COV_BTB_TAKEN: cover property (take && dec_cls == CLS_BTB && btb_taken);
    COV_INTERRUPT_EXIT: cover property (take && dec_cls == CLS_INTERRUPT_EXIT ##2 pop_o);
    COV_BACK: cover property (done_o && take);

endmodule : cbj_core

// ===== include/cbj_pkg.sv
// ============================================================================
package cbj_pkg;

    localparam int          PC_W       = 12;
    localparam logic [2:0]  CYC_BIT    = 3'h4;
    localparam logic [2:0]  CYC_CTRL   = 3'h2;
    localparam logic [2:0]  CYC_JMP    = 3'h4;
    localparam logic [2:0]  CYC_SBR    = 3'h2;
    localparam logic [2:0]  CYC_BTB    = 3'h5;
    localparam logic [1:0]  LEN_NONE   = 2'h0;
    localparam logic [1:0]  LEN_ONE    = 2'h1;
    localparam logic [1:0]  LEN_TWO    = 2'h2;
    localparam logic [1:0]  LEN_THREE  = 2'h3;
    localparam logic [7:0]  OPC_NOP    = 8'h04;
    localparam logic [7:0]  OPC_RET    = 8'hcd;
    localparam logic [7:0]  OPC_INTERRUPT_EXIT   = 8'h4d;
    localparam logic [7:0]  OPC_STOP   = 8'h6d;
    localparam logic [7:0]  OPC_WAIT   = 8'hed;
    localparam logic [3:0]  LOW_CALL   = 4'h1;
    localparam logic [3:0]  LOW_BTB    = 4'h3;
    localparam logic [3:0]  LOW_ILL5   = 4'h5;
    localparam logic [3:0]  LOW_ILL7   = 4'h7;
    localparam logic [3:0]  LOW_JP     = 4'h9;
    localparam logic [3:0]  LOW_BSC    = 4'hb;
    localparam logic [1:0]  COND_NZ    = 2'h0;
    localparam logic [1:0]  COND_NC    = 2'h1;
    localparam logic [1:0]  COND_Z     = 2'h2;
    localparam logic [1:0]  COND_C     = 2'h3;
    localparam logic [11:0] SBR_BIAS   = 12'h001;
    localparam logic [11:0] BTB_BIAS   = 12'h002;
    localparam logic [11:0] BTB_NEXT   = 12'h003;
    localparam logic [11:0] JMP_NEXT   = 12'h002;

    typedef enum logic [3:0] {
        CLS_OTHER = 4'h0,
        CLS_SBR   = 4'h1,
        CLS_BTB   = 4'h2,
        CLS_BSC   = 4'h3,
        CLS_JP    = 4'h4,
        CLS_CALL  = 4'h5,
        CLS_NOP   = 4'h6,
        CLS_RET   = 4'h7,
        CLS_INTERRUPT_EXIT  = 4'h8,
        CLS_STOP  = 4'h9,
        CLS_WAIT  = 4'ha,
        CLS_ILL   = 4'hb
    } cbj_cls_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } cbj_state_t;

    function automatic logic [2:0] bit_index(input logic [3:0] hi);
        bit_index = {hi[1], hi[2], hi[3]};
    endfunction : bit_index

    function automatic logic [11:0] sext5(input logic [4:0] d);
        sext5 = {{7{d[4]}}, d};
    endfunction : sext5

    function automatic logic [11:0] sext8(input logic [7:0] d);
        sext8 = {{4{d[7]}}, d};
    endfunction : sext8

endpackage : cbj_pkg

// ===== verilog/cbj_decode.sv
module cbj_decode
(
    input  wire logic [7:0]       opcode_i,
    output cbj_pkg::cbj_cls_t     cls_o,
    output logic      [1:0]       len_o,
    output logic      [2:0]       cyc_o,
    output logic      [2:0]       bit_o
);
    import cbj_pkg::*;

    logic [3:0] hi;
    logic [3:0] lo;

    assign hi = opcode_i[7:4];
    assign lo = opcode_i[3:0];
    assign bit_o = bit_index(hi);

    // ========================================================================
    // Opcode classification.
    always_comb
    begin
        cls_o = CLS_OTHER;
        len_o = LEN_NONE;
        cyc_o = CYC_CTRL;
        if (opcode_i == OPC_NOP || opcode_i == OPC_RET || opcode_i == OPC_INTERRUPT_EXIT ||
            opcode_i == OPC_STOP || opcode_i == OPC_WAIT)
        begin
            len_o = LEN_ONE;
            cyc_o = CYC_CTRL;
            case (opcode_i)
                OPC_NOP:  cls_o = CLS_NOP;
                OPC_RET:  cls_o = CLS_RET;
                OPC_INTERRUPT_EXIT: cls_o = CLS_INTERRUPT_EXIT;
                OPC_STOP: cls_o = CLS_STOP;
                default:  cls_o = CLS_WAIT;
            endcase
        end
        else if (!lo[0])
        begin
            cls_o = CLS_SBR;
            len_o = LEN_ONE;
            cyc_o = CYC_SBR;
        end
        else
        begin
            case (lo)
                LOW_CALL, LOW_JP:
                begin
                    cls_o = (lo == LOW_JP) ? CLS_JP : CLS_CALL;
                    len_o = LEN_TWO;
                    cyc_o = CYC_JMP;
                end
                LOW_BTB:
                begin
                    cls_o = CLS_BTB;
                    len_o = LEN_THREE;
                    cyc_o = CYC_BTB;
                end
                LOW_BSC:
                begin
                    cls_o = CLS_BSC;
                    len_o = LEN_TWO;
                    cyc_o = CYC_BIT;
                end
                LOW_ILL5:
                begin
                    if (!hi[0])
                    begin
                        cls_o = CLS_ILL;
                    end
                end
                LOW_ILL7:
                begin
                    if (hi == 4'h7 || hi == 4'h9 || hi == 4'hf)
                    begin
                        cls_o = CLS_ILL;
                    end
                end
                default:
                begin
                    cls_o = CLS_OTHER;
                end
            endcase
        end
    end

endmodule : cbj_decode

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cbj_pkg::*;

    logic                sys_clk_i;
    logic                resetn_i;
    logic                start_i;
    logic [7:0]          opcode_i;
    logic [7:0]          op1_i;
    logic [7:0]          op2_i;
    logic [PC_W-1:0]     pc_i;
    logic [PC_W-1:0]     stack_pc_i;
    logic                flag_z_i;
    logic                flag_c_i;
    logic                saved_z_i;
    logic                saved_c_i;
    logic [7:0]          mem_data_i;
    logic                wdg_sel_i;
    logic                busy_o;
    logic                done_o;
    logic                handled_o;
    logic                illegal_o;
    logic [1:0]          len_o;
    logic [PC_W-1:0]     next_pc_o;
    logic [PC_W-1:0]     ret_pc_o;
    logic                z_o;
    logic                c_o;
    logic [7:0]          data_addr_o;
    logic [7:0]          wr_data_o;
    logic                wr_en_o;
    logic                push_o;
    logic                pop_o;
    logic                wait_req_o;
    logic                stop_req_o;
    int                  n_fail;
    int                  n_tests;
    int                  ncyc;

    cbj_core i_cbj_core (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .start_i(start_i),
        .opcode_i(opcode_i), .op1_i(op1_i), .op2_i(op2_i), .pc_i(pc_i),
        .stack_pc_i(stack_pc_i), .flag_z_i(flag_z_i), .flag_c_i(flag_c_i),
        .saved_z_i(saved_z_i), .saved_c_i(saved_c_i), .mem_data_i(mem_data_i),
        .wdg_sel_i(wdg_sel_i), .busy_o(busy_o), .done_o(done_o), .handled_o(handled_o),
        .illegal_o(illegal_o), .len_o(len_o), .next_pc_o(next_pc_o), .ret_pc_o(ret_pc_o),
        .z_o(z_o), .c_o(c_o), .data_addr_o(data_addr_o), .wr_data_o(wr_data_o),
        .wr_en_o(wr_en_o), .push_o(push_o), .pop_o(pop_o), .wait_req_o(wait_req_o),
        .stop_req_o(stop_req_o));

    // ========================================================================
    // Shared tasks.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Presents one instruction and waits for its done pulse.
    task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] m, input logic w);
        opcode_i   = op;
        op1_i      = a;
        op2_i      = b;
        mem_data_i = m;
        wdg_sel_i  = w;
        start_i    = 1'b1;
        @(posedge sys_clk_i);
        #1;
        start_i = 1'b0;
        ncyc    = 1;
        while (done_o !== 1'b1 && ncyc < 12)
        begin
            @(posedge sys_clk_i);
            #1;
            ncyc++;
        end
    endtask : run

    task automatic chk_res(input logic [2:0] ec, input logic [1:0] el,
                           input logic [1:0] ezc, input logic [4:0] ep);
        check(16'(ncyc), 16'(ec));
        check(16'(len_o), 16'(el));
        check(16'({z_o, c_o}), 16'(ezc));
        check(16'({wr_en_o, push_o, pop_o, wait_req_o, stop_req_o}), 16'(ep));
    endtask : chk_res

    // ========================================================================
    // Scenarios.
    task automatic t_bit_modify();
        logic [7:0] op;
        logic [7:0] ew;
        for (int h = 0; h < 16; h++)
        begin
            op = {4'(h), 4'hb};
            ew = 8'h5a;
            ew[{op[5], op[6], op[7]}] = op[4];
            flag_z_i = 1'(h);
            flag_c_i = 1'(h >> 1);
            run(op, 8'h3c, 8'h00, 8'h5a, 1'b0);
            chk_res(3'h4, 2'h2, {flag_z_i, flag_c_i}, 5'b10000);
            check(16'(wr_data_o), 16'(ew));
            check(16'(data_addr_o), 16'h003c);
        end
        flag_z_i = 1'b1;
        flag_c_i = 1'b0;
        $display("test bit_modify done");
    endtask : t_bit_modify

    task automatic t_control();
        logic [7:0] ops [6] = '{8'h04, 8'hcd, 8'h4d, 8'h6d, 8'h6d, 8'hed};
        logic       wdg [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        logic [4:0] pul [6] = '{5'h00, 5'h04, 5'h04, 5'h01, 5'h02, 5'h02};
        for (int i = 0; i < 6; i++)
        begin
            run(ops[i], 8'h00, 8'h00, 8'h00, wdg[i]);
            chk_res(3'h2, 2'h1, (i == 2) ? {saved_z_i, saved_c_i} : {flag_z_i, flag_c_i},
                    pul[i]);
            check(16'(handled_o), 16'h0001);
            if (i < 3)
                check(16'(next_pc_o), 16'((i == 0) ? pc_i + 12'h001 : stack_pc_i));
        end
        $display("test control done");
    endtask : t_control

    task automatic t_jump_call();
        logic [7:0] op;
        logic [7:0] a;
        for (int h = 0; h < 16; h += 5)
            for (int k = 0; k < 2; k++)
            begin
                op = {4'(h), (k == 1) ? 4'h9 : 4'h1};
                a  = 8'(h * 17) ^ 8'h3c;
                run(op, a, 8'h00, 8'h00, 1'b0);
                chk_res(3'h4, 2'h2, {flag_z_i, flag_c_i}, (k == 1) ? 5'h00 : 5'h08);
                check(16'(next_pc_o), 16'({op[7:4], a}));
                if (k == 0)
                    check(16'(ret_pc_o), 16'(pc_i + 12'h002));
            end
        $display("test jump_call done");
    endtask : t_jump_call

    task automatic t_short_branch();
        logic [4:0] d;
        logic       tk;
        for (int cnd = 0; cnd < 4; cnd++)
            for (int f = 0; f < 2; f++)
                for (int s = 0; s < 2; s++)
                begin
                    d        = (s == 1) ? 5'h0f : 5'h10;
                    flag_z_i = 1'(f);
                    flag_c_i = 1'(f);
                    tk       = (cnd / 2) == f;
                    run({d, 2'(cnd), 1'b0}, 8'h00, 8'h00, 8'h00, 1'b0);
                    chk_res(3'h2, 2'h1, {flag_z_i, flag_c_i}, 5'h00);
                    check(16'(next_pc_o), 16'(12'(pc_i + 12'h001 +
                          (tk ? {{7{d[4]}}, d} : 12'h000))));
                end
        flag_z_i = 1'b1;
        flag_c_i = 1'b0;
        $display("test short_branch done");
    endtask : t_short_branch

    task automatic t_bit_test();
        logic [7:0] op;
        logic [7:0] ee;
        logic [7:0] m;
        logic       bv;
        for (int h = 0; h < 16; h++)
        begin
            op       = {4'(h), 4'h3};
            ee       = (h % 4 > 1) ? 8'h80 : 8'h7f;
            m        = (h < 8) ? 8'ha5 : 8'h5a;
            bv       = m[{op[5], op[6], op[7]}];
            flag_c_i = ~bv;
            run(op, 8'h41, ee, m, 1'b0);
            chk_res(3'h5, 2'h3, {flag_z_i, bv}, 5'h00);
            check(16'(next_pc_o), 16'(12'((bv == op[4]) ? pc_i + 12'h002 + {{4{ee[7]}}, ee}
                                                       : pc_i + 12'h003)));
        end
        flag_c_i = 1'b0;
        $display("test bit_test done");
    endtask : t_bit_test

    task automatic t_illegal();
        logic [7:0] ops [11] = '{8'h05, 8'h25, 8'h45, 8'h65, 8'h85, 8'ha5, 8'hc5, 8'he5,
                                 8'h77, 8'h97, 8'hf7};
        for (int i = 0; i < 11; i++)
        begin
            run(ops[i], 8'h00, 8'h00, 8'h00, 1'b0);
            check(16'(illegal_o), 16'h0001);
            chk_res(3'h2, 2'h0, {flag_z_i, flag_c_i}, 5'h00);
        end
        run(8'h07, 8'h00, 8'h00, 8'h00, 1'b0);
        check(16'({illegal_o, handled_o}), 16'h0000);
        check(16'(next_pc_o), 16'(pc_i));
        $display("test illegal done");
    endtask : t_illegal

    task automatic t_refused();
        opcode_i = 8'h39;
        op1_i    = 8'h21;
        start_i  = 1'b1;
        @(posedge sys_clk_i);
        #1;
        start_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
        opcode_i = 8'h04;
        start_i  = 1'b1;
        @(posedge sys_clk_i);
        #1;
        start_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
        check(16'({done_o, len_o}), 16'h0006);
        check(16'(next_pc_o), 16'h0321);
        @(posedge sys_clk_i);
        #1;
        check(16'({busy_o, done_o}), 16'h0000);
        $display("test refused done");
    endtask : t_refused

    // ========================================================================
    // Verdict and run control.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        #100000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        n_fail     = 0;
        n_tests    = 0;
        resetn_i   = 1'b0;
        start_i    = 1'b0;
        opcode_i   = 8'h00;
        op1_i      = 8'h00;
        op2_i      = 8'h00;
        pc_i       = 12'h5f0;
        stack_pc_i = 12'h3a7;
        flag_z_i   = 1'b1;
        flag_c_i   = 1'b0;
        saved_z_i  = 1'b0;
        saved_c_i  = 1'b1;
        mem_data_i = 8'h00;
        wdg_sel_i  = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        #1;
        resetn_i = 1'b1;
        check(16'({busy_o, done_o, len_o}), 16'h0000);
        t_bit_modify();
        t_control();
        t_jump_call();
        t_short_branch();
        t_bit_test();
        t_illegal();
        t_refused();
        finish_test();
    end

endmodule : tb
